// *** dma_ctrl_pkg.sv ***
package dma_ctrl_pkg;

    // register byte offsets on the slave port
    localparam logic [3:0]  OFS_STATUS        = 4'h0;
    localparam logic [3:0]  OFS_CONTROL       = 4'h4;
    localparam logic [3:0]  OFS_NEXT_DESC     = 4'h8;
    localparam logic [31:0] REG_RESET         = 32'h0000_0000;

    // control field positions
    localparam int          CTL_IRQ_ERR       = 0;
    localparam int          CTL_IRQ_EOP       = 1;
    localparam int          CTL_IRQ_DONE      = 2;
    localparam int          CTL_IRQ_CHAIN     = 3;
    localparam int          CTL_IRQ_GLOBAL    = 4;
    localparam int          CTL_RUN           = 5;
    localparam int          CTL_HALT_ERR      = 6;
    localparam int          CTL_IRQ_COUNT     = 7;
    localparam int          CTL_COUNT_LSB     = 8;
    localparam int          CTL_SOFT_RESET    = 16;
    localparam int          CTL_PARK          = 17;
    localparam int          CTL_POLL_EN       = 18;
    localparam int          CTL_POLL_LSB      = 19;
    localparam int          CTL_CLEAR_IRQ     = 31;
    localparam int          FIELD_W           = 8;
    // bits kept in the control flops; 16, 27..30 and 31 are not stored
    localparam logic [31:0] CTL_STORE_MASK    = 32'h07FE_FFFF;

    // status field positions
    localparam int          STS_EVENTS        = 4;
    localparam int          STS_BUSY          = 4;

    // datapath configuration: stream-to-memory
    localparam logic        STREAM_TO_MEMORY  = 1'b1;
    localparam logic [7:0]  POLL_MIN          = 8'h01;
    localparam logic [7:0]  COUNT_ONE         = 8'h01;

    typedef enum logic [1:0] {SRST_IDLE, SRST_ARMED, SRST_FIRE} srst_state_t;

    // host access, one cycle per request, no byte enables
    typedef struct packed {
        logic        write;
        logic        read;
        logic [3:0]  address;
        logic [31:0] writedata;
    } reg_req_t;

    // control handed to the descriptor processor
    typedef struct packed {
        logic        run;
        logic        halt_on_stream_error;
        logic        park;
        logic        poll_enable;
        logic [7:0]  poll_interval;
        logic        soft_reset;
        logic [31:0] desc_addr;
    } engine_ctrl_t;

    // reports from the descriptor processor
    typedef struct packed {
        logic        writeback_done;
        logic        stream_error;
        logic        end_of_packet;
        logic        chain_done;
        logic        descriptor_active;
        logic        addr_load;
        logic [31:0] addr;
    } engine_report_t;

endpackage

// *** scatter_gather_dma_control.sv ***
`timescale 1ns/10ps

// Contract
// R1 - status, control, next address at 0/4/8
// R2 - host must access with 32-bit data
// R3 - next address register feeds descriptor fetch
// R4 - host stops and waits idle before address write
// R5 - interrupt cause on stream error
// R6 - interrupt cause on end of packet
// R7 - interrupt cause on each descriptor done
// R8 - interrupt cause on chain end
// R9 - global enable gates every interrupt
// R10 - run bit starts and keeps processor going
// R11 - clearing run stops after current descriptor
// R12 - halt on stream error, stream-to-memory only
// R13 - interrupt after programmed descriptor count
// R14 - second write of reset bit resets
// R15 - host uses soft reset only as last resort
// R16 - park bit keeps ownership flag set
// R17 - host links last descriptor to first
// R18 - polling updates address register from processor
// R19 - poll interval field, values 1 to 255
// R20 - writing bit 31 clears all pending
// R21 - events counted only after descriptor writeback; chain end is taken without writeback
// R22 - busy follows run one cycle later
// R23 - event flags sticky, write one clears
// R24 - interrupt held while enabled cause pending
// R25 - control bits 27..30 read zero
module scatter_gather_dma_control
(
    // clock and reset
    input  wire logic                          mclk,
    input  wire logic                          rst,
    // register slave port
    input  wire dma_ctrl_pkg::reg_req_t        host_req,
    output      logic [31:0]                   readdata,
    // descriptor processor
    input  wire dma_ctrl_pkg::engine_report_t  report,
    output      dma_ctrl_pkg::engine_ctrl_t    ctrl,
    // interrupt
    output      logic                          irq
);

    logic [31:0]                 control;
    logic [31:0]                 next_control;
    logic [31:0]                 next_desc;
    logic [31:0]                 next_next_desc;
    logic [3:0]                  pending;
    logic [3:0]                  next_pending;
    logic                        busy;
    logic                        next_busy;
    logic                        halted;
    logic                        next_halted;
    logic [7:0]                  desc_count;
    logic [7:0]                  next_desc_count;
    logic                        count_hit;
    logic                        next_count_hit;
    dma_ctrl_pkg::srst_state_t   srst;
    dma_ctrl_pkg::srst_state_t   next_srst;
    logic [31:0]                 next_readdata;
    logic                        next_irq;
    dma_ctrl_pkg::engine_ctrl_t  next_ctrl;

    logic                        wr_status;
    logic                        wr_control;
    logic                        wr_desc;
    logic                        clear_all;
    logic                        err_stop;
    logic [3:0]                  events;
    logic [7:0]                  count_limit;
    logic [7:0]                  poll_field;

    assign wr_status  = host_req.write && host_req.address == dma_ctrl_pkg::OFS_STATUS;
    assign wr_control = host_req.write && host_req.address == dma_ctrl_pkg::OFS_CONTROL;
    assign wr_desc    = host_req.write && host_req.address == dma_ctrl_pkg::OFS_NEXT_DESC;
    assign clear_all  = wr_control && host_req.writedata[dma_ctrl_pkg::CTL_CLEAR_IRQ]; // R20
    assign count_limit = control[dma_ctrl_pkg::CTL_COUNT_LSB +: dma_ctrl_pkg::FIELD_W];
    assign poll_field  = control[dma_ctrl_pkg::CTL_POLL_LSB +: dma_ctrl_pkg::FIELD_W];

    // error, end-of-packet and done events only count once the descriptor has been written back; chain end is taken as it comes
    assign events = {report.chain_done,                                  // R8
                     report.writeback_done,                              // R7 R21
                     report.writeback_done && report.end_of_packet,      // R6 R21
                     report.writeback_done && report.stream_error};      // R5 R21

    assign err_stop = report.writeback_done && report.stream_error
                      && control[dma_ctrl_pkg::CTL_HALT_ERR]
                      && dma_ctrl_pkg::STREAM_TO_MEMORY;                  // R12

    always_comb
    begin
        next_control    = control;
        next_next_desc  = next_desc;
        next_pending    = pending;
        next_busy       = busy;
        next_halted     = halted;
        next_desc_count = desc_count;
        next_count_hit  = count_hit;
        next_srst       = srst;
        next_readdata   = 32'h0000_0000;

        if (wr_control)
        begin
            next_control = host_req.writedata & dma_ctrl_pkg::CTL_STORE_MASK; // R25
            if (!host_req.writedata[dma_ctrl_pkg::CTL_RUN])
            begin
                next_halted = 1'b0;
            end
        end

        // host write wins over a poll update in the same cycle
        if (wr_desc)
        begin
            next_next_desc = host_req.writedata; // R3
        end
        else if (report.addr_load)
        begin
            next_next_desc = report.addr; // R18
        end

        // set beats clear when both land in one cycle
        if (wr_status)
        begin
            next_pending = next_pending & ~host_req.writedata[dma_ctrl_pkg::STS_EVENTS-1:0]; // R23
        end
        if (clear_all)
        begin
            next_pending   = 4'h0; // R20
            next_count_hit = 1'b0; // R20
        end
        next_pending = next_pending | events; // R23

        if (report.writeback_done)
        begin
            if (count_limit != 8'h00 && 8'(desc_count + dma_ctrl_pkg::COUNT_ONE) == count_limit)
            begin
                next_desc_count = 8'h00;
                next_count_hit  = 1'b1; // R13
            end
            else
            begin
                next_desc_count = 8'(desc_count + dma_ctrl_pkg::COUNT_ONE);
            end
        end

        if (err_stop)
        begin
            next_halted = 1'b1; // R12
        end

        // busy drops when the current descriptor has drained, or at once on an error stop or soft reset
        if (!busy)
        begin
            // an error stop in the rising cycle must not leave busy stuck high
            next_busy = control[dma_ctrl_pkg::CTL_RUN] && !halted && !err_stop; // R22 R10
        end
        else if (err_stop)
        begin
            next_busy = 1'b0; // R22
        end
        else if (!control[dma_ctrl_pkg::CTL_RUN] && !report.descriptor_active)
        begin
            next_busy = 1'b0; // R11 R22
        end

        case (srst)
            dma_ctrl_pkg::SRST_IDLE:
            begin
                if (wr_control && host_req.writedata[dma_ctrl_pkg::CTL_SOFT_RESET])
                begin
                    next_srst = dma_ctrl_pkg::SRST_ARMED;
                end
            end
            dma_ctrl_pkg::SRST_ARMED:
            begin
                if (wr_control && host_req.writedata[dma_ctrl_pkg::CTL_SOFT_RESET])
                begin
                    next_srst       = dma_ctrl_pkg::SRST_FIRE; // R14
                    next_control    = dma_ctrl_pkg::REG_RESET;
                    next_next_desc  = dma_ctrl_pkg::REG_RESET;
                    next_pending    = 4'h0;
                    next_busy       = 1'b0;
                    next_halted     = 1'b0;
                    next_desc_count = 8'h00;
                    next_count_hit  = 1'b0;
                end
            end
            dma_ctrl_pkg::SRST_FIRE:
            begin
                next_srst = dma_ctrl_pkg::SRST_IDLE; // R14
            end
            default:
            begin
                next_srst = dma_ctrl_pkg::SRST_IDLE;
            end
        endcase

        if (host_req.read)
        begin
            case (host_req.address)
                dma_ctrl_pkg::OFS_STATUS:
                    next_readdata = {27'h0, busy, pending}; // R1
                dma_ctrl_pkg::OFS_CONTROL:
                begin
                    next_readdata = control; // R25
                    next_readdata[dma_ctrl_pkg::CTL_SOFT_RESET] = srst == dma_ctrl_pkg::SRST_ARMED;
                end
                dma_ctrl_pkg::OFS_NEXT_DESC:
                    next_readdata = next_desc; // R1
                default:
                    next_readdata = 32'h0000_0000;
            endcase
        end

        // irq follows the flags of the same edge
        next_irq = next_control[dma_ctrl_pkg::CTL_IRQ_GLOBAL]
                   && ((|(next_pending & next_control[dma_ctrl_pkg::STS_EVENTS-1:0]))
                       || (next_count_hit && next_control[dma_ctrl_pkg::CTL_IRQ_COUNT])); // R9 R24

        next_ctrl.run                  = next_control[dma_ctrl_pkg::CTL_RUN] && !next_halted; // R10
        next_ctrl.halt_on_stream_error = next_control[dma_ctrl_pkg::CTL_HALT_ERR];
        next_ctrl.park                 = next_control[dma_ctrl_pkg::CTL_PARK]; // R16
        next_ctrl.poll_enable          = next_control[dma_ctrl_pkg::CTL_POLL_EN]; // R18
        // zero is out of range; the processor never sees it
        next_ctrl.poll_interval = (next_control[dma_ctrl_pkg::CTL_POLL_LSB +: dma_ctrl_pkg::FIELD_W]
                                   == 8'h00) ? dma_ctrl_pkg::POLL_MIN
                                  : next_control[dma_ctrl_pkg::CTL_POLL_LSB +: dma_ctrl_pkg::FIELD_W]; // R19
        next_ctrl.soft_reset           = next_srst == dma_ctrl_pkg::SRST_FIRE; // R14
        next_ctrl.desc_addr            = next_next_desc; // R3
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            control    <= 32'h0000_0000;
            next_desc  <= 32'h0000_0000;
            pending    <= 4'h0;
            busy       <= 1'b0;
            halted     <= 1'b0;
            desc_count <= 8'h00;
            count_hit  <= 1'b0;
            srst       <= dma_ctrl_pkg::SRST_IDLE;
            readdata   <= 32'h0000_0000;
            irq        <= 1'b0;
            ctrl       <= '{run: 1'b0, halt_on_stream_error: 1'b0, park: 1'b0,
                            poll_enable: 1'b0, poll_interval: 8'h01, soft_reset: 1'b0,
                            desc_addr: 32'h0000_0000};
        end
        else
        begin
            control    <= next_control;
            next_desc  <= next_next_desc;
            pending    <= next_pending;
            busy       <= next_busy;
            halted     <= next_halted;
            desc_count <= next_desc_count;
            count_hit  <= next_count_hit;
            srst       <= next_srst;
            readdata   <= next_readdata;
            irq        <= next_irq;
            ctrl       <= next_ctrl;
        end
    end

    property p_busy_rise;
        @(posedge mclk) disable iff (rst)
        !busy && !halted && control[5] && !err_stop
        && srst != dma_ctrl_pkg::SRST_ARMED |=> busy;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy did not follow run"); // R22

    property p_busy_hold;
        @(posedge mclk) disable iff (rst)
        busy && control[5] && !err_stop && srst == dma_ctrl_pkg::SRST_IDLE |=> busy;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy fell while running"); // R11

    property p_err_flag;
        @(posedge mclk) disable iff (rst)
        report.writeback_done && report.stream_error |=> pending[0] || ctrl.soft_reset;
    endproperty
    a_err_flag: assert property (p_err_flag) else $error("error flag not set"); // R5

    property p_w1c;
        @(posedge mclk) disable iff (rst)
        pending[2] && wr_status && host_req.writedata[2] && !report.writeback_done
        |=> !pending[2];
    endproperty
    a_w1c: assert property (p_w1c) else $error("done flag not cleared by write one"); // R23

    property p_irq_gate;
        @(posedge mclk) disable iff (rst)
        irq |-> control[4];
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without global enable"); // R9

    property p_irq_done;
        @(posedge mclk) disable iff (rst)
        control[4] && control[2] && pending[2] |-> irq;
    endproperty
    a_irq_done: assert property (p_irq_done) else $error("pending done cause not on irq"); // R24

    property p_clear_all;
        @(posedge mclk) disable iff (rst)
        clear_all && events == 4'h0 |=> pending == 4'h0 && !count_hit;
    endproperty
    a_clear_all: assert property (p_clear_all) else $error("clear did not drop flags"); // R20

    property p_soft_reset;
        @(posedge mclk) disable iff (rst)
        srst == dma_ctrl_pkg::SRST_ARMED && wr_control && host_req.writedata[16]
        |=> ctrl.soft_reset && control == 32'h0 ##1 !ctrl.soft_reset;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset sequence wrong"); // R14

    property p_poll_range;
        @(posedge mclk) disable iff (rst)
        ctrl.poll_interval != 8'h00 && (poll_field == 8'h00 || ctrl.poll_interval == poll_field);
    endproperty
    a_poll_range: assert property (p_poll_range) else $error("poll interval zero"); // R19

    property p_reserved;
        @(posedge mclk) disable iff (rst)
        $past(host_req.read && host_req.address == dma_ctrl_pkg::OFS_CONTROL)
        |-> readdata[30:27] == 4'h0 && readdata[31] == 1'b0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero"); // R25

    property p_halt;
        @(posedge mclk) disable iff (rst)
        err_stop |=> !ctrl.run && !busy;
    endproperty
    a_halt: assert property (p_halt) else $error("no stop on stream error"); // R12

endmodule

// *** desc_engine_model.sv ***
`timescale 1ns/10ps

module desc_engine_model
(
    // clock
    input  wire logic                          mclk,
    // control from the block
    input  wire dma_ctrl_pkg::engine_ctrl_t    ctrl,
    // reports to the block
    output      dma_ctrl_pkg::engine_report_t  report
);
    initial
    begin
        report = '{addr: 32'hFFFF_FFFF, default: '0};
    end

    // pulses last one cycle; address is scrambled once unqualified
    task automatic send(input logic wb, input logic err, input logic eop,
                        input logic chain, input logic load, input logic [31:0] a);
        report = '{writeback_done: wb, stream_error: err, end_of_packet: eop,
                   chain_done: chain, descriptor_active: report.descriptor_active,
                   addr_load: load, addr: a};
        @(posedge mclk);
        #1;
        report = '{writeback_done: 1'b0, stream_error: 1'b0, end_of_packet: 1'b0,
                   chain_done: 1'b0, descriptor_active: report.descriptor_active,
                   addr_load: 1'b0, addr: ~a};
    endtask

    task automatic set_active(input logic a);
        report.descriptor_active = a;
    endtask
endmodule

// *** scatter_gather_dma_control_tb_top.sv ***
`timescale 1ns/10ps

module scatter_gather_dma_control_tb_top;
    localparam logic [3:0]         A_STS = dma_ctrl_pkg::OFS_STATUS;
    localparam logic [3:0]         A_CTL = dma_ctrl_pkg::OFS_CONTROL;
    localparam logic [3:0]         A_NXT = dma_ctrl_pkg::OFS_NEXT_DESC;
    logic                          mclk;
    logic                          rst;
    dma_ctrl_pkg::reg_req_t        host_req;
    logic [31:0]                   readdata;
    dma_ctrl_pkg::engine_report_t  report;
    dma_ctrl_pkg::engine_ctrl_t    ctrl;
    logic                          irq;
    logic [31:0]                   rd;
    int                            n_fail;
    int                            checks_done;

    scatter_gather_dma_control uut (.mclk(mclk), .rst(rst), .host_req(host_req),
        .readdata(readdata), .report(report), .ctrl(ctrl), .irq(irq));
    desc_engine_model eng (.mclk(mclk), .ctrl(ctrl), .report(report));

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // full-word accesses only, taken at the next edge; the strobe stays up
    // so a back-to-back call replaces it in one assignment
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        host_req = '{write: 1'b1, read: 1'b0, address: a, writedata: d};
        @(posedge mclk);
        #1;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        host_req = '{write: 1'b0, read: 1'b1, address: a, writedata: 32'h0};
        @(posedge mclk);
        #1;
        d = readdata;
    endtask

    // released bus shows inverted data, so stale words never pass as fresh
    task automatic bus_off();
        host_req = '{write: 1'b0, read: 1'b0, address: host_req.address,
                     writedata: ~host_req.writedata};
    endtask

    // the bus is let go before a processor report takes its edge
    task automatic pulse(input logic wb, input logic err, input logic eop,
                         input logic chain, input logic load, input logic [31:0] a);
        bus_off();
        eng.send(wb, err, eop, chain, load, a);
    endtask

    task automatic expect_reg(input string what, input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd_reg(a, v);
        check(what, v, exp);
    endtask

    task automatic idle(input int n);
        bus_off();
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // irq seen as a word so that an unknown never matches
    task automatic check_irq(input string what, input logic exp);
        check(what, {31'h0, irq}, {31'h0, exp});
    endtask

    initial
    begin
        #(40 * 4000);
        n_fail++;
        $display("Error run time limit expected %0d seen %0d", 0, 1);
        print_verdict();
    end

    initial
    begin
        n_fail = 0;
        checks_done = 0;
        rst = 1'b1;
        host_req = '0;
        repeat (3) @(posedge mclk);
        #1;
        rst = 1'b0;
        expect_reg("status", A_STS, 32'h0000_0000);
        expect_reg("control", A_CTL, 32'h0000_0000);
        expect_reg("next address", A_NXT, 32'h0000_0000);
        check("poll interval", {24'h0, ctrl.poll_interval}, 32'h0000_0001);
        wr(A_CTL, 32'h7FFE_FFCF);
        expect_reg("control fields", A_CTL, 32'h07FE_FFCF);
        check("ctrl outputs", {20'h0, ctrl.halt_on_stream_error, ctrl.park, ctrl.poll_enable,
            ctrl.run, ctrl.poll_interval}, 32'h0000_0EFF);
        wr(A_CTL, 32'h0000_0000);
        check("zero interval", {24'h0, ctrl.poll_interval}, 32'h0000_0001);
        // run is clear and idle here, so the address may be loaded
        wr(A_NXT, 32'h1234_5670);
        expect_reg("next address", A_NXT, 32'h1234_5670);
        check("fetch address", ctrl.desc_addr, 32'h1234_5670);
        wr(4'hC, 32'hFFFF_FFFF);
        expect_reg("unmapped", 4'hC, 32'h0000_0000);
        expect_reg("control kept", A_CTL, 32'h0000_0000);
        wr(A_CTL, 32'h0000_0034);
        check("run", {31'h0, ctrl.run}, 32'h0000_0001);
        expect_reg("busy late", A_STS, 32'h0000_0000);
        expect_reg("busy", A_STS, 32'h0000_0010);
        pulse(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
        check_irq("irq done", 1'b1);
        expect_reg("done flag", A_STS, 32'h0000_0014);
        wr(A_STS, 32'h0000_0004);
        check_irq("irq cleared", 1'b0);
        expect_reg("flag cleared", A_STS, 32'h0000_0010);
        wr(A_CTL, 32'h0000_002B);
        pulse(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 32'h0);
        check_irq("irq masked", 1'b0);
        expect_reg("error and eop", A_STS, 32'h0000_0017);
        wr(A_CTL, 32'h0000_003B);
        check_irq("irq global", 1'b1);
        wr(A_STS, 32'h0000_000F);
        check_irq("irq all cleared", 1'b0);
        wr(A_CTL, 32'h0000_0032);
        pulse(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
        check_irq("done disabled", 1'b0);
        idle(1);
        pulse(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 32'h0);
        check_irq("irq eop", 1'b1);
        wr(A_CTL, 32'h0000_0038);
        check_irq("eop disabled", 1'b0);
        pulse(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 32'h0);
        check_irq("irq chain", 1'b1);
        wr(A_CTL, 32'h8000_0031);
        check_irq("clear all", 1'b0);
        pulse(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 32'h0);
        check_irq("irq error", 1'b1);
        idle(1);
        pulse(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 32'h0000_0A40);
        expect_reg("polled address", A_NXT, 32'h0000_0A40);
        // wrapped list, park bit clear: the last descriptor links back to the first
        pulse(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 32'h1234_5670);
        expect_reg("wrapped address", A_NXT, 32'h1234_5670);
        // last resort only: nothing is in flight
        wr(A_CTL, 32'h0001_0000);
        expect_reg("reset armed", A_CTL, 32'h0001_0000);
        wr(A_CTL, 32'h0001_0000);
        check("reset pulse", {31'h0, ctrl.soft_reset}, 32'h0000_0001);
        idle(1);
        check("reset pulse ends", {31'h0, ctrl.soft_reset}, 32'h0000_0000);
        expect_reg("control reset", A_CTL, 32'h0000_0000);
        expect_reg("address reset", A_NXT, 32'h0000_0000);
        expect_reg("status reset", A_STS, 32'h0000_0000);
        check_irq("irq reset", 1'b0);
        wr(A_CTL, 32'h0000_02B0);
        pulse(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
        check_irq("count one", 1'b0);
        idle(1);
        pulse(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
        check_irq("count two", 1'b1);
        wr(A_CTL, 32'h8000_0020);
        check_irq("count cleared", 1'b0);
        eng.set_active(1'b1);
        wr(A_CTL, 32'h0000_0000);
        idle(2);
        rd_reg(A_STS, rd);
        check("busy held", rd & 32'h10, 32'h0000_0010);
        pulse(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
        idle(1);
        eng.set_active(1'b0);
        idle(1);
        rd_reg(A_STS, rd);
        check("busy ends", rd & 32'h10, 32'h0000_0000);
        wr(A_STS, 32'h0000_000F);
        wr(A_CTL, 32'h0000_0060);
        eng.set_active(1'b1);
        idle(1);
        pulse(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 32'h0);
        idle(1);
        check("error halt", {31'h0, ctrl.run}, 32'h0000_0000);
        rd_reg(A_STS, rd);
        check("halt status", rd & 32'h11, 32'h0000_0001);
        eng.set_active(1'b0);
        print_verdict();
    end
endmodule
